// ### pps_far_side.sv
// far-side model: adapter, cell, rail and thermistor indications
`timescale 1ns/1ns
module pps_far_side
  import pps_pkg::*;
(
  input  wire logic           clock,
  input  wire logic [NIN-1:0] want,
  output logic      [NIN-1:0] sense_in
);
  // comparators move just after an edge, so the filter never sees a race
  always @(posedge clock) begin
    sense_in <= want;
  end
endmodule

// ### pps_ms_timer.sv
// millisecond prescaler and saturating elapsed-time counter
`timescale 1ns/1ns
module pps_ms_timer
  import pps_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = MS_CYCLES
) (
  input  wire logic clock,
  input  wire logic rst_n,
  pps_tmr_if.tmr    tif
);

  // prescaler must fit its counter and give at least two cycles per tick
  if (TICK_CYCLES < 2 || TICK_CYCLES > 2 ** PSW) begin : g_bad_tick
    $error("TICK_CYCLES out of range");
  end

  typedef struct packed {
    logic [PSW-1:0] pre;
    logic           tick;
    logic [MSW-1:0] ms;
  } pps_tmr_t;

  pps_tmr_t q;
  pps_tmr_t d;

  // restart clears both counters so the next tick is a whole ms away
  always_comb begin
    d      = q;
    d.tick = 1'b0;
    if (q.pre == PSW'(TICK_CYCLES - 1)) begin
      d.pre  = '0;
      d.tick = 1'b1;
      if (q.ms != '1) begin
        d.ms = q.ms + 1'b1;
      end
    end else begin
      d.pre = q.pre + 1'b1;
    end
    if (tif.restart) begin
      d = '0;
    end
  end

  // state register
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign tif.ms_tick = q.tick;
  assign tif.elapsed = q.ms;

endmodule

// ### pps_pkg.sv
// constants, register map and types of the power path sequencer
package pps_pkg;

  // time base: one tick per millisecond
  localparam int unsigned CLK_HZ    = 50_000_000;
  localparam int unsigned TICK_MS   = 1;
  localparam int unsigned MS_CYCLES = CLK_HZ / 1000 * TICK_MS;
  localparam int          PSW       = 16;
  localparam int          MSW       = 10;

  // reset delay choices and waits, in ms
  localparam int unsigned TRST0_MS = 80;
  localparam int unsigned TRST1_MS = 120;
  localparam int unsigned TRST2_MS = 220;
  localparam int unsigned TRST3_MS = 420;
  localparam int unsigned RETRY_MS = 500;
  localparam int unsigned SOFT_MS  = 10;
  localparam int unsigned HARD_MS  = 50;

  // regulators: two bucks, then three LDOs
  localparam int NREG = 5;
  localparam int NLDO = 3;
  localparam int LDO0 = 2;

  // register port
  localparam int AW = 4;
  localparam int DW = 16;
  localparam logic [AW-1:0] A_BOOT = 4'h0;
  localparam logic [AW-1:0] A_SEQ  = 4'h1;
  localparam logic [AW-1:0] A_DOFF = 4'h2;
  localparam logic [AW-1:0] A_AON  = 4'h3;
  localparam logic [AW-1:0] A_HEN  = 4'h4;
  localparam logic [AW-1:0] A_TEMP = 4'h5;
  localparam logic [AW-1:0] A_CMD  = 4'h6;
  localparam logic [AW-1:0] A_STAT = 4'h7;
  localparam logic [AW-1:0] A_PFC  = 4'h8;

  // field positions
  localparam int B_DLY   = 0;
  localparam int B_RETRY = 2;
  localparam int T_MODE  = 0;
  localparam int T_SET   = 2;
  localparam int T_COOL  = 3;
  localparam int T_NORM  = 6;
  localparam int T_WARM  = 9;
  localparam int T_CHG   = 12;
  localparam int C_SOFT  = 0;
  localparam int C_HARD  = 1;

  // reset values
  localparam logic [1:0]      RST_DLY   = 2'h0;
  localparam logic            RST_RETRY = 1'b0;
  localparam logic [2*NREG-1:0] RST_PTS = 10'h0E4;
  localparam logic [NREG-1:0] RST_DOFF  = 5'h00;
  localparam logic [NLDO-1:0] RST_AON   = 3'h0;
  localparam logic [12:0]     RST_TEMP  = 13'h1000;

  // sense input positions
  localparam int SN_DET    = 0;
  localparam int SN_OVP    = 1;
  localparam int SN_ABAT   = 2;
  localparam int SN_AUV    = 3;
  localparam int SN_SYSUV  = 4;
  localparam int SN_SYSP   = 5;
  localparam int SN_BATP   = 6;
  localparam int SN_SYSBAT = 7;
  localparam int SN_COLL   = 8;
  localparam int SN_TLIM   = 9;
  localparam int SN_TSHDN  = 10;
  localparam int SN_ILIM   = 11;
  localparam int SN_B50    = 12;
  localparam int SN_B20    = 13;
  localparam int SN_TSENSE = 14;
  localparam int SN_PFC    = 18;
  localparam int NIN       = 22;

  // charge timer rate codes
  localparam logic [1:0] TR_FULL  = 2'h0;
  localparam logic [1:0] TR_HALF  = 2'h1;
  localparam logic [1:0] TR_PAUSE = 2'h2;

  typedef enum logic [1:0] {TM_OFF, TM_THERM, TM_ZONE1, TM_ZONE2} pps_tmode_t;
  typedef enum logic [2:0] {
    ST_OFF, ST_SEQ, ST_RETRY, ST_SHUT, ST_RUN, ST_SOFT, ST_HARD
  } pps_state_t;

endpackage

// ### pps_power_path_ctrl.sv
// power-on sequencer, load switch and charge control of the power path
//
// Functional notes
// - power function config is read-only; host writes never change it.
// - each regulator starts at 0, 25, 50 or 100 percent of reset delay.
// - two-bit boot delay selects 80, 120, 220 or 420 ms.
// - default-off regulators stay off; host may enable after reset release.
// - always-on LDO stays enabled while system rail or battery present.
// - no valid charger input and system undervoltage: enter off state.
// - retry off and undervoltage in sequencing: shut down, await removal.
// - retry on: recheck undervoltage every 500 ms, then resume sequencing.
// - load switch closed without charger source, open with source.
// - on charger, close load switch when rail falls to battery voltage.
// - below detect threshold external gate follows internal switch.
// - overvoltage lockout alerts host, disables charger, closes switch.
// - input below battery or undervoltage is invalid; close switch.
// - over thermal limit cut charge first; shutdown draws no input.
// - limited below half setting: charge timer at half speed.
// - limited below a fifth of setting: charge timer paused.
// - lower input current limit when charger input collapses.
// - four thermistor comparisons give one of five zones.
// - two selectable default threshold sets for the comparators.
// - separate three-bit fast charge current for each middle zone.
// - thermistor mode charges in two lower middle zones only.
// - zone modes charge in three middle zones; second drops outer termination.
// - mode code 00 off, 01 thermistor, 10 first zone, 11 second zone.
// - soft reset 10 ms low with defaults; hard reset 50 ms full sequence.
`timescale 1ns/1ns
module pps_power_path_ctrl
  import pps_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = MS_CYCLES
) (
  input  wire logic            clock,
  input  wire logic            rst_n,
  input  wire logic [NIN-1:0]  sense_in,
  input  wire logic [AW-1:0]   reg_addr,
  input  wire logic [DW-1:0]   reg_wdata,
  input  wire logic            reg_wr,
  input  wire logic            reg_rd,
  output logic      [DW-1:0]   reg_rdata,
  output logic      [NREG-1:0] reg_en,
  output logic                 sys_reset_n,
  output logic                 load_switch_on,
  output logic                 external_switch_gate,
  output logic                 charger_enable,
  output logic                 input_path_enable,
  output logic                 charge_derate,
  output logic                 input_limit_reduce,
  output logic                 overvoltage_alert,
  output logic      [1:0]      timer_rate,
  output logic      [2:0]      temperature_zone,
  output logic      [2:0]      fast_charge_current,
  output logic                 termination_drop,
  output logic                 threshold_set_select
);

  typedef struct packed {
    logic [NIN-1:0]    s1;
    logic [NIN-1:0]    s2;
    logic [NIN-1:0]    s3;
    logic [NIN-1:0]    f;
    pps_state_t        st;
    logic [MSW-1:0]    seq_ms;
    logic              restart;
    logic [3:0]        pfc;
    logic [1:0]        dly;
    logic              retry;
    logic [2*NREG-1:0] pts;
    logic [NREG-1:0]   doff;
    logic [NREG-1:0]   hen;
    logic [NLDO-1:0]   aon;
    logic [12:0]       temp;
    logic [NREG-1:0]   en;
    logic              rstn;
    logic              lsw;
    logic              gate;
    logic              chg;
    logic              path;
    logic              derate;
    logic              ilim;
    logic              ovalert;
    logic [1:0]        trate;
    logic [2:0]        zone;
    logic [2:0]        ichg;
    logic              drop;
    logic [DW-1:0]     rdata;
  } pps_ctl_t;

  localparam pps_ctl_t RST = '{
    st: ST_SEQ, dly: RST_DLY, retry: RST_RETRY, pts: RST_PTS,
    doff: RST_DOFF, aon: RST_AON, temp: RST_TEMP, restart: 1'b1,
    lsw: 1'b1, default: '0
  };

  pps_ctl_t q;
  pps_ctl_t d;

  pps_tmr_if tif ();

  pps_ms_timer #(
    .TICK_CYCLES (TICK_CYCLES)
  ) u_timer (
    .clock (clock),
    .rst_n (rst_n),
    .tif   (tif.tmr)
  );

  // start point of a regulator within the reset delay
  function automatic logic [MSW-1:0] point_ms(input logic [1:0] code,
                                              input logic [MSW-1:0] t);
    case (code)
      2'h0:    point_ms = '0;
      2'h1:    point_ms = t >> 2;
      2'h2:    point_ms = t >> 1;
      default: point_ms = t;
    endcase
  endfunction

  // reset delay from the boot delay code
  function automatic logic [MSW-1:0] trst_ms(input logic [1:0] sel);
    case (sel)
      2'h0:    trst_ms = MSW'(TRST0_MS);
      2'h1:    trst_ms = MSW'(TRST1_MS);
      2'h2:    trst_ms = MSW'(TRST2_MS);
      default: trst_ms = MSW'(TRST3_MS);
    endcase
  endfunction

  // bit i set means thermistor voltage above threshold i (colder side)
  function automatic logic [2:0] zone_of(input logic [3:0] cmp);
    if (cmp[0]) begin
      zone_of = 3'h0;
    end else if (cmp[1]) begin
      zone_of = 3'h1;
    end else if (cmp[2]) begin
      zone_of = 3'h2;
    end else if (cmp[3]) begin
      zone_of = 3'h3;
    end else begin
      zone_of = 3'h4;
    end
  endfunction

  // whole next-state computation
  always_comb begin
    logic            cv;
    logic            uv;
    logic            tdone;
    logic            cause;
    logic            okz;
    logic [MSW-1:0]  trst;
    logic [NREG-1:0] seq_on;
    logic [2:0]      z;
    cv     = 1'b0;
    uv     = 1'b0;
    tdone  = 1'b0;
    cause  = 1'b0;
    okz    = 1'b0;
    trst   = '0;
    seq_on = '0;
    z      = '0;
    d      = q;

    d.s1 = sense_in;
    d.s2 = q.s1;
    d.s3 = q.s2;
    for (int i = 0; i < NIN; i++) begin
      if (q.s2[i] == q.s3[i]) begin
        d.f[i] = q.s3[i];
      end
    end

    cv = q.f[SN_DET] && !q.f[SN_OVP] && q.f[SN_ABAT] && q.f[SN_AUV];
    uv = q.f[SN_SYSUV];
    trst = trst_ms(q.dly);

    // register writes; command bits are handled with the state machine
    if (reg_wr) begin
      case (reg_addr)
        A_BOOT: begin
          d.dly   = reg_wdata[B_DLY +: 2];
          d.retry = reg_wdata[B_RETRY];
        end
        A_SEQ:  d.pts  = reg_wdata[2*NREG-1:0];
        A_DOFF: d.doff = reg_wdata[NREG-1:0];
        A_AON:  d.aon  = reg_wdata[NLDO-1:0];
        A_HEN: begin
          if (q.st == ST_RUN) begin
            d.hen = reg_wdata[NREG-1:0];
          end
        end
        A_TEMP: d.temp = reg_wdata[12:0];
        default: d.pfc = q.pfc;
      endcase
    end

    // read data stands for the one cycle after the strobe
    d.rdata = '0;
    if (reg_rd) begin
      case (reg_addr)
        A_BOOT: d.rdata = DW'({q.retry, q.dly});
        A_SEQ:  d.rdata = DW'(q.pts);
        A_DOFF: d.rdata = DW'(q.doff);
        A_AON:  d.rdata = DW'(q.aon);
        A_HEN:  d.rdata = DW'(q.hen);
        A_TEMP: d.rdata = DW'(q.temp);
        A_STAT: d.rdata = DW'({q.st, q.zone, cv, q.lsw, q.chg, q.ovalert, q.trate});
        A_PFC:  d.rdata = DW'(q.pfc);
        default: d.rdata = '0;
      endcase
    end

    // waits count from a restart; elapsed is stale while restart is set
    tdone = 1'b0;
    d.restart = 1'b0;
    case (q.st)
      ST_OFF: begin
        // charger insertion wakes the sequencer
        if (cv) begin
          d.st     = ST_SEQ;
          d.seq_ms = '0;
        end
      end
      ST_SEQ: begin
        if (tif.ms_tick && q.seq_ms != '1) begin
          d.seq_ms = q.seq_ms + 1'b1;
        end
        if (uv && !cv) begin
          d.st = ST_OFF;
        end else if (uv && q.retry) begin
          d.st = ST_RETRY;
        end else if (uv) begin
          d.st = ST_SHUT;
        end else if (q.seq_ms >= trst) begin
          d.st = ST_RUN;
        end
      end
      ST_RETRY: begin
        tdone = !q.restart && tif.elapsed >= MSW'(RETRY_MS);
        if (!cv) begin
          d.st = ST_OFF;
        end else if (tdone && !uv) begin
          d.st = ST_SEQ;
        end else if (tdone) begin
          d.restart = 1'b1;
        end
      end
      ST_SHUT: begin
        if (!q.f[SN_DET]) begin
          d.st = ST_OFF;
        end
      end
      ST_RUN: begin
        if (uv && !cv) begin
          d.st = ST_OFF;
        end
      end
      ST_SOFT: begin
        if (!q.restart && tif.elapsed >= MSW'(SOFT_MS)) begin
          d.st = ST_RUN;
        end
      end
      ST_HARD: begin
        if (!q.restart && tif.elapsed >= MSW'(HARD_MS)) begin
          d.st     = ST_SEQ;
          d.seq_ms = '0;
        end
      end
      default: d.st = ST_OFF;
    endcase

    // power commands; hard reset wins over soft
    if (reg_wr && reg_addr == A_CMD && q.st != ST_OFF) begin
      if (reg_wdata[C_HARD]) begin
        d.st = ST_HARD;
      end else if (reg_wdata[C_SOFT] && q.st == ST_RUN) begin
        d.st = ST_SOFT;
      end
    end

    if (d.st != q.st && (d.st == ST_SOFT || d.st == ST_HARD)) begin
      d.dly   = RST_DLY;
      d.retry = RST_RETRY;
      d.pts   = RST_PTS;
      d.doff  = RST_DOFF;
      d.aon   = RST_AON;
      d.temp  = RST_TEMP;
      d.hen   = '0;
    end
    d.restart = d.restart || (d.st != q.st);

    // reset output is released only in normal operation
    d.rstn = (d.st == ST_RUN);

    if (q.st != ST_RUN) begin
      d.pfc = q.f[SN_PFC +: 4];
    end

    for (int r = 0; r < NREG; r++) begin
      seq_on[r] = !q.doff[r] && q.seq_ms >= point_ms(q.pts[2*r +: 2], trst);
    end
    case (q.st)
      ST_SEQ, ST_RETRY: d.en = seq_on;
      ST_RUN, ST_SOFT: d.en = ~q.doff | q.hen;
      default: d.en = '0;
    endcase
    for (int k = 0; k < NLDO; k++) begin
      if (q.aon[k] && (q.f[SN_SYSP] || q.f[SN_BATP])) begin
        d.en[LDO0+k] = 1'b1;
      end
    end

    d.lsw = !cv || q.f[SN_SYSBAT] || q.f[SN_TSHDN];
    d.gate = q.f[SN_DET] ? 1'b0 : d.lsw;
    d.ovalert = q.f[SN_OVP];
    d.derate = q.f[SN_TLIM];
    d.path   = cv && !q.f[SN_TSHDN];
    d.ilim = cv && q.f[SN_COLL];

    // charge timer only slows when the limit or die heat is the cause
    cause = q.f[SN_ILIM] || q.f[SN_TLIM];
    if (cause && q.f[SN_B20]) begin
      d.trate = TR_PAUSE;
    end else if (cause && q.f[SN_B50]) begin
      d.trate = TR_HALF;
    end else begin
      d.trate = TR_FULL;
    end

    z = zone_of(q.f[SN_TSENSE +: 4]);
    d.zone = z;
    // lower termination only in second zone mode
    d.drop = 1'b0;
    case (z)
      3'h1:    d.ichg = q.temp[T_COOL +: 3];
      3'h3:    d.ichg = q.temp[T_WARM +: 3];
      default: d.ichg = q.temp[T_NORM +: 3];
    endcase
    case (pps_tmode_t'(q.temp[T_MODE +: 2]))
      TM_OFF: begin
        okz    = q.temp[T_CHG];
        d.ichg = q.temp[T_NORM +: 3];
      end
      TM_THERM: okz = (z == 3'h1) || (z == 3'h2);
      TM_ZONE1: okz = (z >= 3'h1) && (z <= 3'h3);
      TM_ZONE2: begin
        okz    = (z >= 3'h1) && (z <= 3'h3);
        d.drop = (z == 3'h1) || (z == 3'h3);
      end
      default: okz = 1'b0;
    endcase
    d.chg = okz && d.path;
  end

  // state register; a synchronous reset loads constants only
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      q <= RST;
    end else begin
      q <= d;
    end
  end

  assign tif.restart          = q.restart;
  assign reg_rdata            = q.rdata;
  assign reg_en               = q.en;
  assign sys_reset_n          = q.rstn;
  assign load_switch_on       = q.lsw;
  assign external_switch_gate = q.gate;
  assign charger_enable       = q.chg;
  assign input_path_enable    = q.path;
  assign charge_derate        = q.derate;
  assign input_limit_reduce   = q.ilim;
  assign overvoltage_alert    = q.ovalert;
  assign timer_rate           = q.trate;
  assign temperature_zone     = q.zone;
  assign fast_charge_current  = q.ichg;
  assign termination_drop     = q.drop;
  assign threshold_set_select = q.temp[T_SET];

endmodule

// ### pps_power_path_ctrl_sva.sv
// concurrent checks on the power path controller ports
`timescale 1ns/1ns
module pps_power_path_ctrl_sva
  import pps_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = MS_CYCLES
) (
  input wire logic           clock,
  input wire logic           rst_n,
  input wire logic [NIN-1:0] sense_in,
  input wire logic           sys_reset_n,
  input wire logic           load_switch_on,
  input wire logic           external_switch_gate,
  input wire logic           charger_enable,
  input wire logic           input_path_enable,
  input wire logic           charge_derate,
  input wire logic           input_limit_reduce,
  input wire logic           overvoltage_alert,
  input wire logic [1:0]     timer_rate
);
  logic        in_ok;
  int unsigned lo_cnt_q;
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  // charger input seen as valid on the raw indications
  assign in_ok = sense_in[SN_DET] && sense_in[SN_ABAT] && sense_in[SN_AUV] && !sense_in[SN_OVP];
  // length of the present low phase of the reset output
  always_ff @(posedge clock) begin
    if (!rst_n || sys_reset_n) begin
      lo_cnt_q <= 0;
    end else begin
      lo_cnt_q <= lo_cnt_q + 1;
    end
  end
  // eight cycles cover the three-flop filter plus the output register
  a_overvolt_lockout: assert property (sense_in[SN_OVP] [*8] |->
    overvoltage_alert && load_switch_on && !charger_enable) else $error("lockout not taken");
  a_invalid_closes: assert property ((!sense_in[SN_ABAT] || !sense_in[SN_AUV]) [*8]
    |-> load_switch_on) else $error("switch open on invalid input");
  a_nosrc_closes: assert property ((!sense_in[SN_DET]) [*8] |-> load_switch_on)
    else $error("switch open without source");
  a_ext_follows: assert property ((!sense_in[SN_DET]) [*8]
    |-> external_switch_gate == load_switch_on) else $error("gate mirror wrong");
  a_sysbat_closes: assert property ((in_ok && sense_in[SN_SYSBAT]) [*8]
    |-> load_switch_on) else $error("switch open at cell level");
  a_shdn_no_input: assert property (sense_in[SN_TSHDN] [*8] |-> !input_path_enable)
    else $error("input drawn at shutdown");
  a_derate_hot: assert property ((in_ok && sense_in[SN_TLIM]) [*8] |-> charge_derate)
    else $error("no derate when hot");
  a_timer_half: assert property ((sense_in[SN_ILIM] && sense_in[SN_B50]
    && !sense_in[SN_B20]) [*8] |-> timer_rate == TR_HALF) else $error("timer not half");
  a_timer_pause: assert property (((sense_in[SN_ILIM] || sense_in[SN_TLIM])
    && sense_in[SN_B20]) [*8] |-> timer_rate == TR_PAUSE) else $error("timer not paused");
  a_limit_adapt: assert property ((in_ok && sense_in[SN_COLL]) [*8]
    |-> input_limit_reduce) else $error("limit not lowered");
  a_rst_pulse_min: assert property ($rose(sys_reset_n)
    |-> lo_cnt_q >= SOFT_MS * TICK_CYCLES - 4) else $error("reset pulse short");
  c_overvolt: cover property (sense_in[SN_OVP] ##8 overvoltage_alert);
  c_release: cover property ($rose(sys_reset_n));
  c_pause: cover property (timer_rate == TR_PAUSE);
endmodule

// ### pps_tmr_if.sv
// millisecond timer link between sequencer and its timer
`timescale 1ns/1ns
interface pps_tmr_if;
  import pps_pkg::*;
  logic           restart;
  logic           ms_tick;
  logic [MSW-1:0] elapsed;
  modport ctrl (output restart, input ms_tick, input elapsed);
  modport tmr  (input restart, output ms_tick, output elapsed);
endinterface

// ### tb_top.sv
// self-checking bench for the power path controller
`timescale 1ns/1ns
module tb_top;
  import pps_pkg::*;
  localparam int unsigned TICK_CYCLES = 20;
  localparam logic [NIN-1:0] W_BASE = 22'h140060;
  localparam logic [NIN-1:0] W_V    = 22'h14006D;
  logic            clock = 1'b0;
  logic            rst_n, reg_wr, reg_rd;
  logic [AW-1:0]   reg_addr;
  logic [DW-1:0]   reg_wdata, reg_rdata;
  logic [NIN-1:0]  want, sense_in;
  logic [NREG-1:0] reg_en;
  logic            sys_reset_n, load_switch_on, external_switch_gate, charger_enable;
  logic            input_path_enable, charge_derate, input_limit_reduce, overvoltage_alert;
  logic            termination_drop, threshold_set_select;
  logic [1:0]      timer_rate;
  logic [2:0]      temperature_zone, fast_charge_current;
  int              err_total = 0, comparisons = 0, cyc = 0;
  // free-running clock and cycle count
  always #10 clock = ~clock;
  always @(posedge clock) cyc <= cyc + 1;
  pps_far_side i_far (.clock(clock), .want(want), .sense_in(sense_in));
  pps_power_path_ctrl #(.TICK_CYCLES(TICK_CYCLES)) i_dut (.clock(clock), .rst_n(rst_n),
    .sense_in(sense_in), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_en(reg_en), .sys_reset_n(sys_reset_n),
    .load_switch_on(load_switch_on), .external_switch_gate(external_switch_gate),
    .charger_enable(charger_enable), .input_path_enable(input_path_enable),
    .charge_derate(charge_derate), .input_limit_reduce(input_limit_reduce),
    .overvoltage_alert(overvoltage_alert), .timer_rate(timer_rate),
    .temperature_zone(temperature_zone), .fast_charge_current(fast_charge_current),
    .termination_drop(termination_drop), .threshold_set_select(threshold_set_select));
  task automatic ck(input string n, input logic [15:0] e, input logic [15:0] g);
    comparisons++;
    if (g !== e) begin
      err_total++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
    @(posedge clock);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [AW-1:0] a, input logic [DW-1:0] m, input logic [DW-1:0] e,
                    input string n);
    @(posedge clock);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1;
    ck(n, e & m, reg_rdata & m);
  endtask
  task automatic sense(input logic [NIN-1:0] w);
    want = w;
    repeat (10) @(posedge clock);
    #1;
  endtask
  task automatic at_ms(input int t0, input int ms);
    while (cyc < t0 + ms * TICK_CYCLES) @(posedge clock);
    #1;
  endtask
  task automatic t_seq();
    int t0;
    t0 = cyc;
    rd(A_BOOT, 16'h0007, 16'h0000, "boot");
    rd(A_SEQ, 16'h03FF, 16'h00E4, "points");
    rd(A_TEMP, 16'h1FFF, 16'h1000, "temp");
    rd(4'hF, 16'hFFFF, 16'h0000, "unmapped");
    wr(A_PFC, 16'hFFFF);
    rd(A_PFC, 16'h000F, 16'h0005, "pfc");
    wr(A_DOFF, 16'h0008);
    wr(A_HEN, 16'h0008);
    at_ms(t0, 10);
    ck("lsw", 16'h1, 16'(load_switch_on));
    ck("gate", 16'h1, 16'(external_switch_gate));
    ck("en10", 16'h11, 16'(reg_en));
    at_ms(t0, 30);
    ck("en30", 16'h13, 16'(reg_en));
    at_ms(t0, 60);
    ck("en60", 16'h17, 16'(reg_en));
    at_ms(t0, 78);
    ck("rst78", 16'h0, 16'(sys_reset_n));
    at_ms(t0, 84);
    ck("rst84", 16'h1, 16'(sys_reset_n));
    ck("en84", 16'h17, 16'(reg_en));
    wr(A_HEN, 16'h0008);
    repeat (3) @(posedge clock);
    #1;
    ck("en_host", 16'h1F, 16'(reg_en));
  endtask
  task automatic t_path();
    sense(W_V);
    ck("lsw_src", 16'h0, 16'(load_switch_on));
    ck("gate_src", 16'h0, 16'(external_switch_gate));
    ck("path", 16'h1, 16'(input_path_enable));
    rd(A_STAT, 16'h0020, 16'h0020, "valid");
    sense(W_V | 22'h80);
    ck("lsw_sysbat", 16'h1, 16'(load_switch_on));
    sense(W_V | 22'h2);
    ck("ov_lsw", 16'h1, 16'(load_switch_on));
    ck("ov_int", 16'h1, 16'(overvoltage_alert));
    ck("ov_chg", 16'h0, 16'(charger_enable));
    sense(W_BASE | 22'h9);
    ck("lsw_lowbat", 16'h1, 16'(load_switch_on));
    sense(W_BASE | 22'h5);
    ck("lsw_uvlo", 16'h1, 16'(load_switch_on));
    sense(W_BASE);
    ck("gate_nodet", 16'h1, 16'(external_switch_gate));
  endtask
  task automatic t_timer();
    sense(W_V | 22'h1800);
    ck("half", 16'(TR_HALF), 16'(timer_rate));
    sense(W_V | 22'h3800);
    ck("pause", 16'(TR_PAUSE), 16'(timer_rate));
    sense(W_V | 22'h200);
    ck("derate", 16'h1, 16'(charge_derate));
    sense(W_V | 22'h400);
    ck("shdn", 16'h0, 16'(input_path_enable));
    sense(W_V | 22'h100);
    ck("adapt", 16'h1, 16'(input_limit_reduce));
  endtask
  task automatic t_zones();
    logic [1:0] md;
    logic       en;
    logic [2:0] cur;
    for (int m = 0; m < 4; m++) begin
      md = 2'(m);
      wr(A_TEMP, 16'h1AF0 | {13'h0, md[0], md});
      for (int z = 0; z < 5; z++) begin
        // thermometer code: the colder the zone, the more comparators are set
        sense(W_V | (NIN'(4'(4'hF << z)) << SN_TSENSE));
        en = (m == 0) || (z == 1) || (z == 2) || (m >= 2 && z == 3);
        cur = (m == 0 || z == 2) ? 3'h3 : ((z == 1) ? 3'h6 : 3'h5);
        ck("zone", 16'(z), 16'(temperature_zone));
        ck("chg_en", 16'(en), 16'(charger_enable));
        if (en) ck("cur", 16'(cur), 16'(fast_charge_current));
        ck("drop", 16'(m == 3 && (z == 1 || z == 3)), 16'(termination_drop));
        ck("tset", 16'(md[0]), 16'(threshold_set_select));
      end
    end
  endtask
  task automatic t_uv();
    int t0;
    wr(A_AON, 16'h0001);
    sense(W_BASE | 22'h10);
    rd(A_STAT, 16'h0E00, 16'h0000, "off");
    ck("aon", 16'h04, 16'(reg_en));
    sense(W_V);
    rd(A_STAT, 16'h0E00, 16'h0200, "wake");
    sense(W_V | 22'h10);
    rd(A_STAT, 16'h0E00, 16'h0600, "shut");
    ck("shut_en", 16'h04, 16'(reg_en));
    sense(W_BASE | 22'h10);
    rd(A_STAT, 16'h0E00, 16'h0000, "removed");
    wr(A_BOOT, 16'h0004);
    sense(W_V);
    sense(W_V | 22'h10);
    rd(A_STAT, 16'h0E00, 16'h0400, "retry");
    t0 = cyc;
    sense(W_V);
    at_ms(t0, 100);
    rd(A_STAT, 16'h0E00, 16'h0400, "retry_hold");
    at_ms(t0, 600);
    rd(A_STAT, 16'h0E00, 16'h0800, "resumed");
  endtask
  task automatic t_cmds();
    int t0;
    wr(A_BOOT, 16'h0000);
    wr(A_CMD, 16'h0002);
    t0 = cyc;
    at_ms(t0, 5);
    ck("hard_rst", 16'h0, 16'(sys_reset_n));
    ck("hard_en", 16'h00, 16'(reg_en));
    at_ms(t0, 125);
    ck("hard_125", 16'h0, 16'(sys_reset_n));
    at_ms(t0, 136);
    ck("hard_136", 16'h1, 16'(sys_reset_n));
    wr(A_BOOT, 16'h0003);
    wr(A_CMD, 16'h0001);
    t0 = cyc;
    at_ms(t0, 8);
    ck("soft_8", 16'h0, 16'(sys_reset_n));
    at_ms(t0, 12);
    ck("soft_12", 16'h1, 16'(sys_reset_n));
    rd(A_BOOT, 16'h0007, 16'h0000, "boot_dflt");
  endtask
  task automatic test_done();
    $display("Comparisons %0d errors %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // main sequence: two reset cycles, then each scenario in turn
  initial begin
    rst_n = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = '0;
    reg_wdata = '0;
    want = W_BASE;
    repeat (2) @(posedge clock);
    rst_n <= 1'b1;
    t_seq();
    t_path();
    t_timer();
    t_zones();
    t_uv();
    t_cmds();
    test_done();
  end
  // watchdog: about twice the expected run
  initial begin
    repeat (40000) @(posedge clock);
    err_total++;
    $display("Error watchdog expected finish seen timeout");
    test_done();
  end
endmodule
bind pps_power_path_ctrl pps_power_path_ctrl_sva #(.TICK_CYCLES(TICK_CYCLES)) i_sva (
  .clock(clock), .rst_n(rst_n), .sense_in(sense_in), .sys_reset_n(sys_reset_n),
  .load_switch_on(load_switch_on), .external_switch_gate(external_switch_gate),
  .charger_enable(charger_enable), .input_path_enable(input_path_enable),
  .charge_derate(charge_derate), .input_limit_reduce(input_limit_reduce),
  .overvoltage_alert(overvoltage_alert), .timer_rate(timer_rate));
